//--- sim/adc_spi_event_trigger_select_bench.sv
// Self-checking bench of the event trigger select block
`timescale 1ns/1ns
module adc_spi_event_trigger_select_bench;
  import aets_pkg::*;
  typedef struct packed {
    logic [7:0]  off;
    logic [31:0] val;
    logic [5:0]  src;
    logic [21:0] rm;
    logic [21:0] fm;
  } aets_row_type;
  localparam aets_row_type ROWS [13] = '{
    '{8'h00, 32'h0, 6'h00, 22'h7, 22'h7},
    '{8'h04, 32'h0, 6'h01, 22'h38, 22'h38},
    '{8'h00, 32'h1, 6'h15, 22'h1, 22'h1},
    '{8'h00, 32'h2, 6'h17, 22'h1, 22'h1},
    '{8'h00, 32'hBB, 6'h02, 22'h0, 22'h3},
    '{8'h00, 32'h33, 6'h02, 22'h3, 22'h3},
    '{8'h00, 32'h400, 6'h1E, 22'h4, 22'h4},
    '{8'h04, 32'h5, 6'h20, 22'h8, 22'h8},
    '{8'h04, 32'h60, 6'h03, 22'h10, 22'h10},
    '{8'h04, 32'h700, 6'h04, 22'h20, 22'h20},
    '{8'h0C, 32'hE0000000, 6'h1F, 22'h200000, 22'h200000},
    '{8'h0C, 32'h0D000000, 6'h1D, 22'h100000, 22'h100000},
    '{8'h0C, 32'h0, 6'h05, 22'h0, 22'h0}};
  logic                 pclk, presetn, psel, penable, pwrite, clr;
  logic                 pready, pslverr, held_err, e;
  logic [7:0]           paddr;
  aets_word_type        pwdata, prdata, r;
  logic [44:0]          src;
  logic [2:0]           c1t, c2t;
  logic [7:0]           t1, t3;
  logic [31:0]          d1, d3;
  logic [21:0][7:0]     cnt;
  int                   failures, num_checks, cycles;
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  aets_trigger_select #(.NUM_TG(8)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .converter_one_event_pin(src[0]), .converter_two_event_pin(src[1]),
    .real_time_compare_zero(src[2]), .general_port_b(src[4:3]),
    .general_port_a(src[12:5]), .high_end_timer_channel(src[44:13]),
    .converter_one_trig(c1t), .converter_two_trig(c2t),
    .serial_port_one_tg_trig(t1), .serial_port_three_tg_trig(t3),
    .serial_port_one_tg_dma(d1), .serial_port_three_tg_dma(d3));
  aets_consumer_model #(.W(22)) partner (.pclk(pclk), .presetn(presetn),
    .clr(clr), .trig({t3, t1, c2t, c1t}), .cnt(cnt), .held_err(held_err));
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_word(input aets_word_type got, input aets_word_type exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t count %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input aets_word_type d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk_trig(input logic [21:0] m);
    for (int i = 0; i < 22; i++) begin
      chk_cnt(cnt[i], {7'h00, m[i]});
    end
  endtask
  task automatic run_case(input logic [7:0] a, input aets_word_type v,
                          input int s, input logic [21:0] rm, fm);
    apb(1'b1, a, v);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    src[s] <= 1'b1;
    repeat (8) @(posedge pclk);
    chk_trig(rm);
    src[s] <= 1'b0;
    repeat (8) @(posedge pclk);
    chk_trig(fm);
    apb(1'b0, a, 32'h0);
    chk_word(r, v);
    $display("case %h %h done", a, v);
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      complete_run;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, clr} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    src = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk_word(r, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk_word(r, 32'h0);
    foreach (ROWS[k]) begin
      run_case(ROWS[k].off, ROWS[k].val, ROWS[k].src, ROWS[k].rm,
               ROWS[k].fm);
    end
    for (int c = 1; c < 15; c++) begin
      run_case(8'h08, c, (c < 9) ? 4 + c : 21 + 2 * (c - 9),
               22'h40, 22'h40);
    end
    apb(1'b1, 8'h10, 32'h76543210);
    apb(1'b1, 8'h14, 32'hFEDCBA98);
    @(posedge pclk);
    chk_word(d1, 32'h76543210);
    chk_word(d3, 32'hFEDCBA98);
    apb(1'b1, 8'h24, 32'hFFFFFFFF);
    chk_word({31'h0, e}, 32'h1);
    apb(1'b0, 8'h24, 32'h0);
    chk_word(r, 32'h0);
    src[2] <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, 8'h1C, 32'h0);
    chk_word(r, 32'h4);
    src[2] <= 1'b0;
    apb(1'b1, 8'h18, 32'h3);
    apb(1'b1, 8'h0C, 32'hF);
    repeat (10) @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (41) @(posedge pclk);
    chk_cnt(cnt[14], 8'h0A);
    chk_word({31'h0, held_err}, 32'h0);
    $display("tick case done");
    complete_run;
  end
endmodule

//--- sim/aets_consumer_model.sv
// Model of the conversion groups and transfer-group sequencers
`timescale 1ns/1ns
module aets_consumer_model #(
  parameter int W = 22
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clr,
  input  wire logic [W-1:0] trig,
  output logic [W-1:0][7:0] cnt,
  output logic              held_err
);
  logic [W-1:0] prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      prev_q <= '0;
      held_err <= 1'b0;
    end else begin
      prev_q <= trig;
      if ((trig & prev_q) != '0) begin
        held_err <= 1'b1;
      end
      for (int i = 0; i < W; i++) begin
        if (clr) begin
          cnt[i] <= 8'h00;
        end else if (trig[i]) begin
          cnt[i] <= cnt[i] + 8'h01;
        end
      end
    end
  end
endmodule

//--- src/aets_params.svh
// Constants of the event trigger select block
`ifndef AETS_PARAMS_SVH
`define AETS_PARAMS_SVH
`define AETS_OFF_ADC1      8'h00
`define AETS_OFF_ADC2      8'h04
`define AETS_OFF_SP1_TG    8'h08
`define AETS_OFF_SP3_TG    8'h0C
`define AETS_OFF_SP1_DMA   8'h10
`define AETS_OFF_SP3_DMA   8'h14
`define AETS_OFF_TICK      8'h18
`define AETS_OFF_STAT_LO   8'h1C
`define AETS_OFF_STAT_HI   8'h20
`define AETS_GRP_W         4
`define AETS_POL_BIT       3
`define AETS_ADC_RST       12'h000
`define AETS_TG_RST        32'h00000000
`define AETS_TICK_RST      16'h0000
`define AETS_SRC_AD1       0
`define AETS_SRC_AD2       1
`define AETS_SRC_RTC0      2
`define AETS_SRC_GPB       3
`define AETS_SRC_GPA       5
`define AETS_SRC_HET       13
`define AETS_SRC_W         45
`define AETS_HET_W         32
`define AETS_NUM_TG        8
`endif

//--- src/aets_pkg.sv
// Types of the event trigger select block
package aets_pkg;
  typedef enum logic [2:0] {
    ADC_SRC_PIN    = 3'h0,
    ADC_SRC_HET8   = 3'h1,
    ADC_SRC_HET10  = 3'h2,
    ADC_SRC_RTC0   = 3'h3,
    ADC_SRC_HET17  = 3'h4,
    ADC_SRC_HET19  = 3'h5,
    ADC_SRC_GPB0   = 3'h6,
    ADC_SRC_GPB1   = 3'h7
  } aets_adc_src_type;
  typedef enum logic [3:0] {
    TG_SRC_OFF     = 4'h0,
    TG_SRC_TICK    = 4'hF
  } aets_tg_src_type;
  typedef logic [31:0] aets_word_type;
endpackage

//--- src/aets_trigger_select.sv
// Converter and serial port event trigger routing with APB registers
//
// Behaviour
// R1: Three conversion groups per converter, each event-triggerable alone.
// R2: Every group has its own source select and edge polarity field.
// R3: Converter codes: pin, timer 8, 10, compare 0, 17, 19, port B 0, 1.
// R4: Second converter maps alike; code 0 is its own event pin.
// R5: All sources stay routed internally whether bonded out or not.
// R6: Software drives pin sources externally or as toggled outputs.
// R7: Compare 0 line high on event; rising polarity triggers on assertion.
// R8: Falling polarity triggers when the compare 0 line deasserts.
// R9: Transfer groups start on pin, timer or periodic tick events.
// R10: Group codes: off, port A 0-7, timer 8-18 even, tick counter.
// R11: Second serial port decodes transfer group triggers identically.
// R12: Each transfer group carries its own DMA channel number.
// R13: Sources synchronised; one pulse per qualifying edge.
// R14: Reset gives zero codes and rising polarity, no spurious trigger.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "aets_params.svh"
module aets_trigger_select #(
  parameter int NUM_TG = `AETS_NUM_TG
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire aets_pkg::aets_word_type  pwdata,
  output logic                          pready,
  output aets_pkg::aets_word_type       prdata,
  output logic                          pslverr,
  input  wire logic                     converter_one_event_pin,
  input  wire logic                     converter_two_event_pin,
  input  wire logic                     real_time_compare_zero,
  input  wire logic [`AETS_HET_W-1:0]   high_end_timer_channel,
  input  wire logic [7:0]               general_port_a,
  input  wire logic [1:0]               general_port_b,
  output logic [2:0]                    converter_one_trig,
  output logic [2:0]                    converter_two_trig,
  output logic [NUM_TG-1:0]             serial_port_one_tg_trig,
  output logic [NUM_TG-1:0]             serial_port_three_tg_trig,
  output logic [NUM_TG*4-1:0]           serial_port_one_tg_dma,
  output logic [NUM_TG*4-1:0]           serial_port_three_tg_dma
);
  import aets_pkg::*;

  localparam int SW = `AETS_SRC_W;
  localparam int TW = NUM_TG * 4;

  if (NUM_TG < 1 || NUM_TG > 8) begin : g_chk
    $error("NUM_TG must lie between 1 and 8");
  end

  typedef struct packed {
    logic [SW-1:0]         s1;
    logic [SW-1:0]         s2;
    logic [SW-1:0]         s3;
    logic [SW-1:0]         lvl;
    logic [1:0][11:0]      adc_sel;
    logic [1:0][TW-1:0]    tg_sel;
    logic [1:0][TW-1:0]    tg_dma;
    logic [15:0]           tick_per;
    logic [15:0]           tick_cnt;
    logic                  tick;
    logic [1:0][2:0]       adc_trig;
    logic [1:0][NUM_TG-1:0] tg_trig;
    logic                  ready;
    aets_word_type         rdata;
    logic                  err;
  } aets_state_type;

  aets_state_type st_q;
  aets_state_type st_d;

  logic [SW-1:0] src_w;
  logic [SW-1:0] rise_w;
  logic [SW-1:0] fall_w;
  logic          wr_w;

  // R3 R4: converter source decode, shared
  function automatic logic adc_pick(logic [2:0] code, logic second,
                                    logic [SW-1:0] e);
    logic r;
    r = 1'b0;
    unique case (aets_adc_src_type'(code))
      ADC_SRC_PIN:   r = second ? e[`AETS_SRC_AD2] : e[`AETS_SRC_AD1];
      ADC_SRC_HET8:  r = e[`AETS_SRC_HET + 8];
      ADC_SRC_HET10: r = e[`AETS_SRC_HET + 10];
      ADC_SRC_RTC0:  r = e[`AETS_SRC_RTC0];
      ADC_SRC_HET17: r = e[`AETS_SRC_HET + 17];
      ADC_SRC_HET19: r = e[`AETS_SRC_HET + 19];
      ADC_SRC_GPB0:  r = e[`AETS_SRC_GPB];
      ADC_SRC_GPB1:  r = e[`AETS_SRC_GPB + 1];
    endcase
    return r;
  endfunction

  // Transfer group source decode, shared by both serial ports
  function automatic logic tg_pick(logic [3:0] code, logic [SW-1:0] e,
                                   logic tk);
    logic r;
    int   i;
    r = 1'b0;
    i = int'(code);
    if (code == TG_SRC_OFF) begin
      r = 1'b0;
    end else if (code <= 4'h8) begin
      r = e[`AETS_SRC_GPA + i - 1];
    end else if (code == TG_SRC_TICK) begin
      r = tk;
    end else begin
      r = e[`AETS_SRC_HET + 8 + 2 * (i - 9)];
    end
    return r;
  endfunction

  function automatic aets_word_type rd_mux(logic [7:0] a,
                                           aets_state_type s);
    aets_word_type r;
    r = '0;
    unique case (a)
      `AETS_OFF_ADC1:    r = {20'h00000, s.adc_sel[0]};
      `AETS_OFF_ADC2:    r = {20'h00000, s.adc_sel[1]};
      `AETS_OFF_SP1_TG:  r = 32'(s.tg_sel[0]);
      `AETS_OFF_SP3_TG:  r = 32'(s.tg_sel[1]);
      `AETS_OFF_SP1_DMA: r = 32'(s.tg_dma[0]);
      `AETS_OFF_SP3_DMA: r = 32'(s.tg_dma[1]);
      `AETS_OFF_TICK:    r = {16'h0000, s.tick_per};
      `AETS_OFF_STAT_LO: r = s.lvl[31:0];
      `AETS_OFF_STAT_HI: r = 32'(s.lvl[SW-1:32]);
      default:           r = '0;
    endcase
    return r;
  endfunction

  function automatic logic mapped(logic [7:0] a);
    return a <= `AETS_OFF_STAT_HI && a[1:0] == 2'b00;
  endfunction

  // R5: all sources always routed
  assign src_w = {high_end_timer_channel, general_port_a, general_port_b,
                  real_time_compare_zero, converter_two_event_pin,
                  converter_one_event_pin};

  assign wr_w = psel && penable && st_q.ready && pwrite
                && mapped(paddr);

  always_comb begin
    st_d = st_q;
    // R13: three-stage sync, level taken when stages two and three agree
    st_d.s1 = src_w;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.lvl = (st_q.s2 & ~(st_q.s2 ^ st_q.s3))
             | (st_q.lvl & (st_q.s2 ^ st_q.s3));
    rise_w = st_d.lvl & ~st_q.lvl;
    fall_w = ~st_d.lvl & st_q.lvl;

    // R9: periodic tick counter, stopped while period is zero
    st_d.tick = 1'b0;
    if (st_q.tick_per == 16'h0000) begin
      st_d.tick_cnt = 16'h0000;
    end else if (st_q.tick_cnt >= st_q.tick_per) begin
      st_d.tick_cnt = 16'h0000;
      st_d.tick = 1'b1;
    end else begin
      st_d.tick_cnt = st_q.tick_cnt + 16'h0001;
    end

    // R1 R2 R7 R8: per group source and polarity; R4 second pin on code 0
    for (int k = 0; k < 2; k++) begin
      for (int g = 0; g < 3; g++) begin
        st_d.adc_trig[k][g] = adc_pick(
          st_q.adc_sel[k][g*`AETS_GRP_W +: 3], k[0],
          st_q.adc_sel[k][g*`AETS_GRP_W + `AETS_POL_BIT] ? fall_w : rise_w);
      end
    end

    // R10 R11: same decode for both serial ports, tick as code 15
    for (int k = 0; k < 2; k++) begin
      for (int t = 0; t < NUM_TG; t++) begin
        st_d.tg_trig[k][t] = tg_pick(st_q.tg_sel[k][t*4 +: 4], rise_w,
                                     st_q.tick);
      end
    end

    // APB: one wait state, answer registered
    st_d.ready = 1'b0;
    if (psel && penable && !st_q.ready) begin
      st_d.ready = 1'b1;
      st_d.rdata = pwrite ? '0 : rd_mux(paddr, st_q);
      st_d.err = !mapped(paddr);
    end else if (!(psel && penable)) begin
      st_d.rdata = '0;
      st_d.err = 1'b0;
    end

    // R2 R12: register writes take effect at the completing edge
    if (wr_w) begin
      unique case (paddr)
        `AETS_OFF_ADC1:    st_d.adc_sel[0] = pwdata[11:0];
        `AETS_OFF_ADC2:    st_d.adc_sel[1] = pwdata[11:0];
        `AETS_OFF_SP1_TG:  st_d.tg_sel[0] = pwdata[TW-1:0];
        `AETS_OFF_SP3_TG:  st_d.tg_sel[1] = pwdata[TW-1:0];
        `AETS_OFF_SP1_DMA: st_d.tg_dma[0] = pwdata[TW-1:0];
        `AETS_OFF_SP3_DMA: st_d.tg_dma[1] = pwdata[TW-1:0];
        `AETS_OFF_TICK:    st_d.tick_per = pwdata[15:0];
        default:           st_d.tick_per = st_q.tick_per;
      endcase
    end
  end

  // R14: zero codes and rising polarity after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.adc_sel <= {2{`AETS_ADC_RST}};
      st_q.tg_sel <= '0;
      st_q.tick_per <= `AETS_TICK_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign pready = st_q.ready;
  assign prdata = st_q.rdata;
  assign pslverr = st_q.err;
  assign converter_one_trig = st_q.adc_trig[0];
  assign converter_two_trig = st_q.adc_trig[1];
  assign serial_port_one_tg_trig = st_q.tg_trig[0];
  assign serial_port_three_tg_trig = st_q.tg_trig[1];
  assign serial_port_one_tg_dma = st_q.tg_dma[0];
  assign serial_port_three_tg_dma = st_q.tg_dma[1];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence gpb0_held_s;
    $rose(general_port_b[0]) ##1 general_port_b[0] [*4];
  endsequence

  // R13: level follows a held pin after synchronisation
  sync_level_a: assert property ( // R13
    gpb0_held_s |-> st_q.lvl[`AETS_SRC_GPB])
    else $error("synchronised level missed a held pin");

  // R13: a stable selection never gives back-to-back pulses
  single_pulse_a: assert property ( // R13
    converter_one_trig[0] && $stable(st_q.adc_sel[0])
    |=> !converter_one_trig[0])
    else $error("trigger pulse longer than one cycle");

  // R7: rising polarity on compare 0 line
  rtc_rise_a: assert property ( // R7
    rise_w[`AETS_SRC_RTC0] && st_q.adc_sel[0][3:0] == 4'h3
    |=> converter_one_trig[0])
    else $error("compare 0 assertion did not trigger");

  // R8: falling polarity on compare 0 line
  rtc_fall_a: assert property ( // R8
    fall_w[`AETS_SRC_RTC0] && st_q.adc_sel[0][7:4] == 4'hB
    |=> converter_one_trig[1])
    else $error("compare 0 deassertion did not trigger");

  // R4: code 0 on the second converter uses its own pin
  adc2_pin_a: assert property ( // R4
    rise_w[`AETS_SRC_AD2] && st_q.adc_sel[1][11:8] == 4'h0
    |=> converter_two_trig[2])
    else $error("second converter pin did not trigger");

  // R10: port A bit 0 on code 1
  tg_porta_a: assert property ( // R10
    rise_w[`AETS_SRC_GPA] && st_q.tg_sel[0][3:0] == 4'h1
    |=> serial_port_one_tg_trig[0])
    else $error("port A bit 0 did not trigger group 0");

  // R10: code 0 never triggers
  tg_off_a: assert property ( // R10
    st_q.tg_sel[1][3:0] == 4'h0 |=> !serial_port_three_tg_trig[0])
    else $error("disabled group triggered");

  // R9: tick counter drives code 15
  tg_tick_a: assert property ( // R9
    st_q.tick && st_q.tg_sel[1][3:0] == 4'hF
    |=> serial_port_three_tg_trig[0])
    else $error("tick did not trigger group");

  // R2: completed write loads the selected group fields
  adc_write_a: assert property ( // R2
    psel && penable && pready && pwrite && paddr == `AETS_OFF_ADC1
    |=> st_q.adc_sel[0] == $past(pwdata[11:0]))
    else $error("converter select write lost");

  // R2: second converter select write lands
  adc2_write_a: assert property ( // R2
    psel && penable && pready && pwrite && paddr == `AETS_OFF_ADC2
    |=> st_q.adc_sel[1] == $past(pwdata[11:0]))
    else $error("second converter select write lost");

  // R2: writing one converter leaves the other alone
  adc_isolate_a: assert property ( // R2
    psel && penable && pready && pwrite && paddr == `AETS_OFF_ADC1
    |=> $stable(st_q.adc_sel[1]))
    else $error("converter one write disturbed converter two");

  // R11: second serial port group codes written
  tg_write_a: assert property ( // R11
    psel && penable && pready && pwrite && paddr == `AETS_OFF_SP3_TG
    |=> st_q.tg_sel[1] == $past(pwdata[TW-1:0]))
    else $error("serial three group write lost");

  // R12: first serial port DMA channels follow write
  dma_one_a: assert property ( // R12
    psel && penable && pready && pwrite && paddr == `AETS_OFF_SP1_DMA
    |=> serial_port_one_tg_dma == $past(pwdata[TW-1:0]))
    else $error("serial one DMA channels lost");

  // R12: second serial port DMA channels follow write
  dma_three_a: assert property ( // R12
    psel && penable && pready && pwrite && paddr == `AETS_OFF_SP3_DMA
    |=> serial_port_three_tg_dma == $past(pwdata[TW-1:0]))
    else $error("serial three DMA channels lost");

  // R10: code 0 never triggers the first serial port
  tg_off_one_a: assert property ( // R10
    st_q.tg_sel[0][3:0] == 4'h0 |=> !serial_port_one_tg_trig[0])
    else $error("disabled serial one group triggered");

  // R10: code 9 takes timer channel 8
  tg_het8_a: assert property ( // R10
    rise_w[`AETS_SRC_HET + 8] && st_q.tg_sel[0][3:0] == 4'h9
    |=> serial_port_one_tg_trig[0])
    else $error("timer 8 did not trigger group 0");

  // R4: second converter code 5 takes timer channel 19
  adc2_het19_a: assert property ( // R4
    rise_w[`AETS_SRC_HET + 19] && st_q.adc_sel[1][3:0] == 4'h5
    |=> converter_two_trig[0])
    else $error("timer 19 did not trigger converter two");

  // R3: code 7 takes port B bit 1
  gpb1_event_a: assert property ( // R3
    rise_w[`AETS_SRC_GPB + 1] && st_q.adc_sel[1][11:8] == 4'h7
    |=> converter_two_trig[2])
    else $error("port B bit 1 did not trigger event group");

  // R9: tick is a single cycle pulse
  tick_gap_a: assert property ( // R9
    st_q.tick |=> !st_q.tick)
    else $error("tick held for two cycles");
endmodule
